// >>> supervision_pkg.sv
// Package for the breaker supervision and reclose configuration block.
// Assumes one 200 MHz clock and APB register access.
`default_nettype none
package supervision_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PICKUP = 8'h08;
   localparam logic [7:0] OFS_EVENTS = 8'h0C;
   // ==========================================================
   // Config field positions
   localparam int CFG_SLOW_LSB   = 0;   // 6-bit slow trip time, cycles
   localparam int CFG_ROT_ACB    = 8;
   localparam int CFG_RMS        = 9;
   localparam int CFG_DELAYED    = 10;
   localparam int CFG_ALTERNATE_GROUP_ONE_EN    = 11;
   localparam int CFG_ALTERNATE_GROUP_TWO_EN    = 12;
   localparam int CFG_MDT_EN     = 13;
   localparam int CFG_COLD_MIN   = 14;
   localparam int CFG_VBLK_MIN   = 15;
   localparam int CFG_ZONE_EN    = 16;
   localparam int CFG_TGT_ALL    = 17;
   localparam int CFG_DEMAND_LSB = 18;  // 2 bits: 5,15,30,60 min
   // ==========================================================
   // Limits, values after reset and codes
   localparam logic [5:0]  SLOW_MIN     = 6'h05;
   localparam logic [5:0]  SLOW_MAX     = 6'h3C;
   localparam logic [5:0]  SLOW_DEFAULT = 6'h12;  // 18 cycles
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0012;
   localparam logic [3:0]  TRIP_HOLD    = 4'h3;   // cycles after drop
   localparam logic [1:0]  DMD_5 = 2'h0;
   localparam logic [1:0]  DMD_15 = 2'h1;
   localparam logic [1:0]  DMD_30 = 2'h2;
   localparam logic [1:0]  DMD_60 = 2'h3;
   // ==========================================================
   // Timing: one power-system cycle tick
   localparam int CLK_MHZ   = 200;
   localparam int SYS_HZ    = 60;
   localparam int TICK_CLKS = CLK_MHZ * 1000000 / SYS_HZ;
endpackage : supervision_pkg
`default_nettype wire

// >>> breaker_supervision.sv
// Breaker supervision, MULTIPLE_DEVICE_TRIP_MODE trip/reclose/lockout and zone sequence logic.
// Assumes current comparisons are done upstream; APB slave for config.
//
// Contract
// - Trip starts slow-trip timer, 5-60, default 18
// - Timer expiry before open sets slow breaker
// - Open in time resets; rearm on reclose
// - Phase rotation ABC or ACB selectable
// - Fundamental or RMS operating quantity selectable
// - Instantaneous or delayed reset mode selectable
// - Alt group needs enable, mapping, true input
// - MULTIPLE_DEVICE_TRIP_MODE ignores both aux contacts in the open breaker test
// - MULTIPLE_DEVICE_TRIP_MODE removes trip 3 cycles after drop
// - MULTIPLE_DEVICE_TRIP_MODE reclose needs OC trip and low current
// - MULTIPLE_DEVICE_TRIP_MODE lockout clears: b open, currents, reset
// - MULTIPLE_DEVICE_TRIP_MODE lockout clears: b open, targets, reset
// - MULTIPLE_DEVICE_TRIP_MODE reclose inputs need b contact
// - MULTIPLE_DEVICE_TRIP_MODE forces instantaneous reset mode
// - MULTIPLE_DEVICE_TRIP_MODE disabled by default
// - Cold-load and voltage-block time unit selects
// - Zone coordination needs enable and mapping
// - Zone coordination advances reclose sequence
// - Zone step: above pickup, drops before delay
// - Zone step starts reset time, records step
// - Target display last or accumulated
// - Demand interval 5, 15, 30 or 60 min
// - Open breaker: contacts open, current below 5%
`timescale 1ns/100ps
`default_nettype none
module breaker_supervision #(
   parameter int TICK_CLKS = supervision_pkg::TICK_CLKS
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // APB
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Breaker and current status
   input  wire logic        breaker_aux_contact_a_i,
   input  wire logic        breaker_aux_contact_b_i,
   input  wire logic        trip_request_i,
   input  wire logic        oc_trip_i,
   input  wire logic        above_low_pickup_i,
   input  wire logic        below_90pct_pickup_i,
   input  wire logic        below_5pct_phase_pickup_i,
   input  wire logic        all_above_5pct_phase_pickup_i,
   input  wire logic        element_delay_expired_i,
   input  wire logic        reset_time_expired_i,
   input  wire logic        target_reset_i,
   input  wire logic        lockout_i,
   // Mapped logical inputs
   input  wire logic        alternate_group_one_mapped_i,
   input  wire logic        alternate_group_one_i,
   input  wire logic        alternate_group_two_mapped_i,
   input  wire logic        alternate_group_two_i,
   input  wire logic        zone_sequence_coordination_mapped_i,
   input  wire logic        single_shot_reclose_input_i,
   input  wire logic        multi_shot_reclose_input_i,
   // Outputs
   output logic             slow_breaker_o,
   output logic             trip_o,
   output logic             reclose_start_o,
   output logic             lockout_clear_o,
   output logic             zone_step_o,
   output logic             reset_timer_start_o,
   output logic             alt_one_active_o,
   output logic             alt_two_active_o,
   output logic             rotation_acb_o,
   output logic             use_rms_o,
   output logic             delayed_reset_o,
   output logic             cold_load_minutes_o,
   output logic             voltage_block_reclose_time_minutes_o,
   output logic             target_show_all_o,
   output logic      [1:0]  demand_interval_o,
   output logic             cycle_tick_o
);
   // ==========================================================
   // Registers
   typedef enum logic [1:0] {SUP_ARMED, SUP_TIMING, SUP_OPENED} sup_t;
   typedef enum logic [1:0] {ZS_IDLE, ZS_ABOVE} zs_t;

   logic [31:0] config_q;
   logic [31:0] tick_cnt;
   logic [5:0]  slow_cnt;
   logic [3:0]  hold_cnt;
   logic [7:0]  zone_steps;
   logic [7:0]  fault_steps;
   logic        oc_tripped;
   logic        trip_req_d;
   sup_t        sup_state;
   zs_t         zs_state;

   // ==========================================================
   // Configuration decode
   wire [5:0] cfg_slow = config_q[supervision_pkg::CFG_SLOW_LSB +: 6];
   wire       multiple_device_trip_mode      = config_q[supervision_pkg::CFG_MDT_EN];
   wire       zone_en  = config_q[supervision_pkg::CFG_ZONE_EN] &
                         zone_sequence_coordination_mapped_i;
   wire       tick     = (tick_cnt == 32'(TICK_CLKS - 1));
   wire       wr_en    = psel_i & penable_i & pwrite_i;
   wire       addr_ok  = (paddr_i == supervision_pkg::OFS_CONFIG) |
                         (paddr_i == supervision_pkg::OFS_STATUS) |
                         (paddr_i == supervision_pkg::OFS_PICKUP) |
                         (paddr_i == supervision_pkg::OFS_EVENTS);
   // Out-of-range slow trip writes clamp into the legal span
   wire [5:0] wr_slow  = pwdata_i[5:0] < supervision_pkg::SLOW_MIN ?
                         supervision_pkg::SLOW_MIN :
                         pwdata_i[5:0] > supervision_pkg::SLOW_MAX ?
                         supervision_pkg::SLOW_MAX : pwdata_i[5:0];
   // Open breaker test, aux contacts skipped in MULTIPLE_DEVICE_TRIP_MODE mode
   wire       contacts_open = multiple_device_trip_mode ? 1'b1 :
                         (~breaker_aux_contact_a_i &
                          breaker_aux_contact_b_i);
   wire       breaker_open = contacts_open &
                         below_5pct_phase_pickup_i;
   wire       trip_rise = trip_request_i & ~trip_req_d;
   wire       b_open   = ~breaker_aux_contact_b_i;
   wire       clear_a  = b_open & all_above_5pct_phase_pickup_i &
                         reset_time_expired_i;
   wire       clear_b  = b_open & target_reset_i &
                         reset_time_expired_i;
   wire       reclose_in = single_shot_reclose_input_i |
                         multi_shot_reclose_input_i;
   wire       reclose_ok = multiple_device_trip_mode ?
                         (oc_tripped & below_90pct_pickup_i &
                          breaker_aux_contact_b_i) :
                         (reclose_in & breaker_open);
   wire       zone_fire = zone_en & (zs_state == ZS_ABOVE) &
                         below_90pct_pickup_i &
                         ~element_delay_expired_i;

   // ==========================================================
   // APB slave: zero wait state
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         config_q  <= supervision_pkg::CONFIG_RESET;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
         pready_o  <= 1'b0;
      end else begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~addr_ok;
         if (wr_en && pready_o && paddr_i == supervision_pkg::OFS_CONFIG)
            config_q <= {12'h000, pwdata_i[19:8], 2'h0, wr_slow};
         if (psel_i && !penable_i) begin
            case (paddr_i)
               supervision_pkg::OFS_CONFIG: prdata_o <= config_q;
               supervision_pkg::OFS_STATUS: prdata_o <=
                  {24'h000000, 1'b0, oc_tripped, lockout_clear_o,
                   alt_two_active_o, alt_one_active_o, trip_o,
                   sup_state == SUP_TIMING, slow_breaker_o};
               supervision_pkg::OFS_PICKUP: prdata_o <=
                  {26'h0000000, slow_cnt};
               supervision_pkg::OFS_EVENTS: prdata_o <=
                  {16'h0000, fault_steps, zone_steps};
               default: prdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Cycle tick divider
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt     <= 32'h0000_0000;
         cycle_tick_o <= 1'b0;
      end else begin
         tick_cnt     <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
         cycle_tick_o <= tick;
      end
   end

   // ==========================================================
   // Slow trip supervision
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sup_state      <= SUP_ARMED;
         slow_cnt       <= 6'h00;
         slow_breaker_o <= 1'b0;
         trip_req_d     <= 1'b0;
      end else begin
         trip_req_d <= trip_request_i;
         case (sup_state)
            SUP_ARMED: if (trip_rise) begin
               sup_state      <= SUP_TIMING;
               slow_cnt       <= 6'h00;
               slow_breaker_o <= 1'b0;
            end
            SUP_TIMING: if (tick) begin
               if (breaker_open)
                  sup_state <= SUP_OPENED;
               else if (slow_cnt + 6'h01 >= cfg_slow) begin
                  slow_breaker_o <= 1'b1;
                  sup_state      <= SUP_OPENED;
               end else
                  slow_cnt <= slow_cnt + 6'h01;
            end
            SUP_OPENED: if (tick && !breaker_open && !trip_request_i)
               sup_state <= SUP_ARMED;
            default: sup_state <= SUP_ARMED;
         endcase
      end
   end

   // ==========================================================
   // Trip output and MULTIPLE_DEVICE_TRIP_MODE reclose/lockout
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trip_o          <= 1'b0;
         hold_cnt        <= 4'h0;
         oc_tripped      <= 1'b0;
         reclose_start_o <= 1'b0;
         lockout_clear_o <= 1'b0;
      end else begin
         reclose_start_o <= 1'b0;
         lockout_clear_o <= 1'b0;
         if (oc_trip_i)
            oc_tripped <= 1'b1;
         if (trip_request_i) begin
            trip_o   <= 1'b1;
            hold_cnt <= 4'h0;
         end else if (tick && trip_o) begin
            if (!multiple_device_trip_mode)
               trip_o <= 1'b0;
            else if (!below_90pct_pickup_i)
               hold_cnt <= 4'h0;
            else if (hold_cnt + 4'h1 >= supervision_pkg::TRIP_HOLD)
               trip_o <= 1'b0;
            else
               hold_cnt <= hold_cnt + 4'h1;
         end
         if (tick && reclose_ok && (multiple_device_trip_mode ? 1'b1 : oc_tripped)) begin
            reclose_start_o <= 1'b1;
            oc_tripped      <= oc_trip_i;
         end
         if (tick && multiple_device_trip_mode && lockout_i && (clear_a || clear_b))
            lockout_clear_o <= 1'b1;
      end
   end

   // ==========================================================
   // Zone sequence coordination
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         zs_state            <= ZS_IDLE;
         zone_step_o         <= 1'b0;
         reset_timer_start_o <= 1'b0;
         zone_steps          <= 8'h00;
         fault_steps         <= 8'h00;
      end else begin
         zone_step_o         <= 1'b0;
         reset_timer_start_o <= 1'b0;
         if (tick) begin
            case (zs_state)
               ZS_IDLE: if (zone_en && above_low_pickup_i)
                  zs_state <= ZS_ABOVE;
               ZS_ABOVE: begin
                  if (zone_fire) begin
                     zone_step_o         <= 1'b1;
                     reset_timer_start_o <= 1'b1;
                     zone_steps          <= zone_steps + 8'h01;
                     fault_steps         <= fault_steps + 8'h01;
                  end
                  if (!zone_en || element_delay_expired_i || zone_fire)
                     zs_state <= ZS_IDLE;
               end
               default: zs_state <= ZS_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // Static mode outputs
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         alt_one_active_o <= 1'b0;
         alt_two_active_o <= 1'b0;
         rotation_acb_o   <= 1'b0;
         use_rms_o        <= 1'b0;
         delayed_reset_o  <= 1'b0;
         cold_load_minutes_o                  <= 1'b0;
         voltage_block_reclose_time_minutes_o <= 1'b0;
         target_show_all_o <= 1'b0;
         demand_interval_o <= supervision_pkg::DMD_5;
      end else begin
         alt_one_active_o <= config_q[supervision_pkg::CFG_ALTERNATE_GROUP_ONE_EN] &
            alternate_group_one_mapped_i & alternate_group_one_i;
         alt_two_active_o <= config_q[supervision_pkg::CFG_ALTERNATE_GROUP_TWO_EN] &
            alternate_group_two_mapped_i & alternate_group_two_i;
         rotation_acb_o  <= config_q[supervision_pkg::CFG_ROT_ACB];
         use_rms_o       <= config_q[supervision_pkg::CFG_RMS];
         delayed_reset_o <= config_q[supervision_pkg::CFG_DELAYED] &
                            ~multiple_device_trip_mode;
         cold_load_minutes_o <=
            config_q[supervision_pkg::CFG_COLD_MIN];
         voltage_block_reclose_time_minutes_o <=
            config_q[supervision_pkg::CFG_VBLK_MIN];
         target_show_all_o <= config_q[supervision_pkg::CFG_TGT_ALL];
         demand_interval_o <=
            config_q[supervision_pkg::CFG_DEMAND_LSB +: 2];
      end
   end

   // ==========================================================
   // Checks
   chk_mdt_inst_reset: assert property (@(posedge clk_i)
      disable iff (!resetn_i) multiple_device_trip_mode |=> !delayed_reset_o)
      else $error("delayed reset while MULTIPLE_DEVICE_TRIP_MODE on");
   chk_alt_gate: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      !alternate_group_one_mapped_i |=> !alt_one_active_o)
      else $error("alt one active while unmapped");
   chk_slow_flag: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      $rose(slow_breaker_o) |-> $past(sup_state) == SUP_TIMING)
      else $error("slow flag without timing");
   chk_zone_gate: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      zone_step_o |-> $past(zone_en))
      else $error("zone step while disabled");
   chk_zone_reset: assert property (@(posedge clk_i)
      disable iff (!resetn_i) zone_step_o |-> reset_timer_start_o)
      else $error("zone step without reset timer");
   chk_trip_set: assert property (@(posedge clk_i)
      disable iff (!resetn_i) trip_request_i |=> trip_o)
      else $error("trip not raised");
   chk_clear_mdt: assert property (@(posedge clk_i)
      disable iff (!resetn_i) lockout_clear_o |-> $past(multiple_device_trip_mode))
      else $error("lockout cleared outside MULTIPLE_DEVICE_TRIP_MODE");
   chk_tick_rate: assert property (@(posedge clk_i)
      disable iff (!resetn_i) cycle_tick_o |=> !cycle_tick_o)
      else $error("tick longer than one clock");
endmodule : breaker_supervision
`default_nettype wire

// >>> breaker_model.sv
// Breaker model: auxiliary contacts and low-current flag of one breaker.
// Assumes the bench sets the opening delay and commands each reclose.
`timescale 1ns/100ps
`default_nettype none
module breaker_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // Control from the relay side
   input  wire logic       trip_i,
   input  wire logic       close_i,
   input  wire logic [7:0] open_delay_i,
   // Breaker state
   output logic            aux_a_o,
   output logic            aux_b_o,
   output logic            below_5pct_o
);
   logic [7:0] wait_cnt;
   logic       is_open;
   // ==========================================================
   // Contacts
   // Both contacts and the current flag move together on opening
   assign aux_a_o      = !is_open;
   assign aux_b_o      = is_open;
   assign below_5pct_o = is_open;
   // ==========================================================
   // Mechanism
   // A long delay models a sluggish breaker that misses the window
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         is_open  <= 1'b0;
         wait_cnt <= 8'h00;
      end else if (close_i) begin
         is_open  <= 1'b0;
         wait_cnt <= 8'h00;
      end else if (trip_i && !is_open) begin
         wait_cnt <= wait_cnt + 8'h01;
         is_open  <= (wait_cnt == open_delay_i);
      end
   end
endmodule : breaker_model
`default_nettype wire

// >>> test_breaker_supervision.sv
// Testbench for the breaker supervision block with a breaker model.
// Assumes a short cycle tick of 8 clocks and single-word APB access.
`timescale 1ns/100ps
`default_nettype none
module test_breaker_supervision;
   localparam int TICK = 8;
   logic        clk_i, resetn_i, psel_i, penable_i, pwrite_i;
   logic [7:0]  paddr_i, open_delay;
   logic [31:0] pwdata_i, prdata_o, cfg, rnd;
   logic        pready_o, pslverr_o, close_cmd, a1, a2;
   logic        breaker_aux_contact_a_i, breaker_aux_contact_b_i;
   logic        trip_request_i, oc_trip_i, above_low_pickup_i;
   logic        below_90pct_pickup_i, below_5pct_phase_pickup_i;
   logic        all_above_5pct_phase_pickup_i, element_delay_expired_i;
   logic        reset_time_expired_i, target_reset_i, lockout_i;
   logic        alternate_group_one_mapped_i, alternate_group_one_i;
   logic        alternate_group_two_mapped_i, alternate_group_two_i;
   logic        zone_sequence_coordination_mapped_i;
   logic        single_shot_reclose_input_i, multi_shot_reclose_input_i;
   logic        slow_breaker_o, trip_o, reclose_start_o, lockout_clear_o;
   logic        zone_step_o, reset_timer_start_o, alt_one_active_o;
   logic        alt_two_active_o, rotation_acb_o, use_rms_o, delayed_reset_o;
   logic        cold_load_minutes_o, voltage_block_reclose_time_minutes_o;
   logic        target_show_all_o, cycle_tick_o;
   logic [1:0]  demand_interval_o;
   logic [32:0] exp_q[$];
   int          err_count, n_checks, zs_cnt, rt_cnt, rs_cnt, z0, r0;
   int          lc_cnt;
   int          seed = 32'h8CB0;
   breaker_supervision #(.TICK_CLKS(TICK)) breaker_supervision_inst (
      .clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .breaker_aux_contact_a_i,
      .breaker_aux_contact_b_i, .trip_request_i, .oc_trip_i,
      .above_low_pickup_i, .below_90pct_pickup_i, .below_5pct_phase_pickup_i,
      .all_above_5pct_phase_pickup_i, .element_delay_expired_i,
      .reset_time_expired_i, .target_reset_i, .lockout_i,
      .alternate_group_one_mapped_i, .alternate_group_one_i,
      .alternate_group_two_mapped_i, .alternate_group_two_i,
      .zone_sequence_coordination_mapped_i, .single_shot_reclose_input_i,
      .multi_shot_reclose_input_i, .slow_breaker_o, .trip_o,
      .reclose_start_o, .lockout_clear_o, .zone_step_o, .reset_timer_start_o,
      .alt_one_active_o, .alt_two_active_o, .rotation_acb_o, .use_rms_o,
      .delayed_reset_o, .cold_load_minutes_o,
      .voltage_block_reclose_time_minutes_o, .target_show_all_o,
      .demand_interval_o, .cycle_tick_o);
   breaker_model breaker_model_inst (
      .clk_i, .resetn_i, .trip_i(trip_o), .close_i(close_cmd),
      .open_delay_i(open_delay), .aux_a_o(breaker_aux_contact_a_i),
      .aux_b_o(breaker_aux_contact_b_i),
      .below_5pct_o(below_5pct_phase_pickup_i));
   // ==========================================================
   // Clock, watchdog and checking
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = !clk_i;
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      err_count++;
      final_report();
   end
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("errors %0d checks %0d", err_count, n_checks);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   // Read answers are matched against the oldest queued note
   always @(posedge clk_i) begin
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
         if (exp_q[0][32])
            check(pslverr_o, 1'b1);
         else
            check({pslverr_o, prdata_o}, exp_q[0]);
         void'(exp_q.pop_front());
      end
      zs_cnt += (zone_step_o === 1'b1);
      rt_cnt += (reset_timer_start_o === 1'b1);
      rs_cnt += (reclose_start_o === 1'b1);
      lc_cnt += (lockout_clear_o === 1'b1);
   end
   // ==========================================================
   // Bus and tick helpers
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      if (!wr)
         exp_q.push_back(e);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // Only the watchdog ends a wait for the slave's answer
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_i);
         while (cycle_tick_o !== 1'b1)
            @(posedge clk_i);
      end
      repeat (2) @(posedge clk_i);
   endtask : ticks
   // ==========================================================
   // Main sequence
   initial begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {trip_request_i, oc_trip_i, above_low_pickup_i} = '0;
      {below_90pct_pickup_i, all_above_5pct_phase_pickup_i} = '0;
      {element_delay_expired_i, reset_time_expired_i, target_reset_i} = '0;
      {lockout_i, single_shot_reclose_input_i} = '0;
      {multi_shot_reclose_input_i, zone_sequence_coordination_mapped_i} = '0;
      {alternate_group_one_mapped_i, alternate_group_one_i} = '0;
      {alternate_group_two_mapped_i, alternate_group_two_i} = '0;
      {close_cmd, resetn_i} = '0;
      open_delay = 8'h04;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      apb(1'b0, supervision_pkg::OFS_CONFIG, 32'h0, 33'h0_0000_0012);
      apb(1'b1, 8'h10, 32'hFFFF_FFFF, 33'h0);
      apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000);
      // Random settings with the slow time kept inside its range
      for (int i = 0; i < 8; i++) begin
         cfg = $random(seed) & 32'h000F_FF3F;
         cfg[5:0] = 6'h05 + 6'(cfg[5:0] % 56);
         rnd = $random(seed);
         a1 = cfg[11] & rnd[0] & rnd[1];
         alternate_group_one_mapped_i <= rnd[0];
         alternate_group_one_i        <= rnd[1];
         alternate_group_two_mapped_i <= rnd[2];
         alternate_group_two_i        <= rnd[3] & !a1;
         a2 = cfg[12] & rnd[2] & rnd[3] & !a1;
         apb(1'b1, supervision_pkg::OFS_CONFIG, cfg, 33'h0);
         apb(1'b0, supervision_pkg::OFS_CONFIG, 32'h0, {1'b0, cfg});
         ticks(4);
         check(rotation_acb_o, cfg[8]);
         check(use_rms_o, cfg[9]);
         check(delayed_reset_o, cfg[10] & !cfg[13]);
         check(cold_load_minutes_o, cfg[14]);
         check(voltage_block_reclose_time_minutes_o, cfg[15]);
         check(target_show_all_o, cfg[17]);
         check(demand_interval_o, cfg[19:18]);
         check({alt_one_active_o, alt_two_active_o}, {a1, a2});
      end
      {alternate_group_one_i, alternate_group_two_i} <= 2'b00;
      // Prompt breaker, then reclose and a sluggish one at the minimum time
      apb(1'b1, supervision_pkg::OFS_CONFIG, 32'h0000_0005, 33'h0);
      trip_request_i <= 1'b1;
      ticks(10);
      check(trip_o, 1'b1);
      check(slow_breaker_o, 1'b0);
      trip_request_i <= 1'b0;
      close_cmd      <= 1'b1;
      open_delay     <= 8'hC8;
      ticks(2);
      close_cmd      <= 1'b0;
      trip_request_i <= 1'b1;
      ticks(4);
      check(slow_breaker_o, 1'b0);
      ticks(3);
      check(slow_breaker_o, 1'b1);
      apb(1'b0, supervision_pkg::OFS_STATUS, 32'h0, 33'h0_0000_0005);
      trip_request_i <= 1'b0;
      close_cmd      <= 1'b1;
      open_delay     <= 8'h04;
      ticks(2);
      close_cmd <= 1'b0;
      // Multiple device trip: trip held three cycles after current drops
      apb(1'b1, supervision_pkg::OFS_CONFIG, 32'h0000_2012, 33'h0);
      r0 = rs_cnt;
      {oc_trip_i, trip_request_i, above_low_pickup_i} <= 3'b111;
      ticks(2);
      {trip_request_i, oc_trip_i} <= 2'b00;
      {above_low_pickup_i, below_90pct_pickup_i} <= 2'b01;
      ticks(1);
      check(trip_o, 1'b1);
      ticks(4);
      check(trip_o, 1'b0);
      check(rs_cnt != r0, 1'b1);
      below_90pct_pickup_i <= 1'b0;
      // Zone step counts only with the function mapped
      apb(1'b1, supervision_pkg::OFS_CONFIG, 32'h0001_0012, 33'h0);
      for (int i = 0; i < 2; i++) begin
         zone_sequence_coordination_mapped_i <= (i == 0);
         {z0, r0} = {zs_cnt, rt_cnt};
         above_low_pickup_i <= 1'b1;
         ticks(2);
         {above_low_pickup_i, below_90pct_pickup_i} <= 2'b01;
         ticks(3);
         below_90pct_pickup_i <= 1'b0;
         check(zs_cnt - z0, (i == 0));
         check(rt_cnt - r0, (i == 0));
      end
      apb(1'b0, supervision_pkg::OFS_EVENTS, 32'h0, 33'h0_0000_0101);
      // MULTIPLE_DEVICE_TRIP_MODE lockout clearing needs b open and the reset time run out
      apb(1'b1, supervision_pkg::OFS_CONFIG, 32'h0000_2012, 33'h0);
      {close_cmd, lockout_i} <= 2'b11;
      for (int i = 0; i < 3; i++) begin
         reset_time_expired_i          <= (i != 0);
         target_reset_i                <= (i != 2);
         all_above_5pct_phase_pickup_i <= (i == 2);
         z0 = lc_cnt;
         ticks(2);
         check(lc_cnt != z0, i != 0);
      end
      final_report();
   end
endmodule : test_breaker_supervision
`default_nettype wire
